// ### core/tdmtx_ctrl.sv
// Purpose: Transmit controller for a time-sliced parallel link.
// Assumes: FIFO read side, CRC datapath and byte counter live outside.
// Notes:   Link logic runs on link_clk; registers run on clk.
`timescale 1ns/1ps
module tdmtx_ctrl (
    input  wire logic        clk,                   // Register clock
    input  wire logic        srst,                  // Sync reset, high
    input  wire logic        link_clk,              // Link clock
    input  wire logic        cmd_wr,                // Command write
    input  wire logic [15:0] cmd_wdata,             // Command data
    output logic [15:0]      tx_command_reg,        // Command readback
    output logic [15:0]      tx_status_reg,         // Status readback
    input  wire logic        count_armed,           // Byte count loaded
    output logic             count_pending_clr,     // Clear count pulse
    output logic             irq_req,               // Interrupt request
    input  wire logic        phase_zero_pulse,      // Link phase 0 pin
    input  wire logic        phase_one_pulse,       // Link phase 1 pin
    input  wire logic [4:0]  bus_tx_addr,           // Slice owner address
    input  wire logic [4:0]  switch_addr,           // Own address strap
    input  wire logic [1:0]  return_response,       // Receiver response
    input  wire logic        bus_reject,            // Receiver reject
    input  wire logic        bus_truncate,          // Receiver truncate
    input  wire logic        bus_master,            // Unit is link master
    output logic [1:0]       forward_response_o,    // Response pins
    output logic             forward_response_oe,   // Response enable
    output logic [15:0]      data_o,                // Data pins
    output logic             data_oe,               // Data enable
    input  wire logic        fifo_empty,            // FIFO has no word
    input  wire logic [15:0] fifo_word,             // FIFO head word
    input  wire logic [15:0] crc_word,              // Check character
    input  wire logic        crc_ready,             // Check char settled
    output logic             fifo_pop_strobe,       // Discard head word
    output logic             fifo_flush,            // Empty the FIFO
    output logic             crc_clear,             // Clear CRC, counter
    output logic             return_capture_strobe, // Return sampled
    output logic             channel_teardown       // Close channel
);
    localparam int PIN_W = 2 * tdmtx_pkg::ADDR_W + 7;

    // Link domain state
    typedef struct packed {
        tdmtx_pkg::tdmtx_state_t st;
        logic        tp0_d;
        logic        tp1_d;
        logic        claimed;
        logic [1:0]  fwd;
        logic [1:0]  fwd_pin;
        logic        ctl_oe;
        logic [1:0]  ret;
        logic        occupied;
        logic        fault;
        logic        live;
        logic        rejected;
        logic        success;
        logic        freeze;
        logic        zero_sent;
        logic        err;
        logic        final_word;
        logic        truncated;
        logic        term;
        logic        pop;
        logic        flush;
        logic        crc_clr;
        logic        cap;
        logic        teardown;
        logic        trunc_tgl;
        logic        irq_tgl;
        logic        init_seen;
        logic        rd_seen;
        logic [15:0] data;
    } tdmtx_link_t;

    // Register domain state
    typedef struct packed {
        logic [15:0] cmd;
        logic        init_tgl;
        logic        rd_tgl;
        logic        trunc_prev;
        logic        irq_prev;
        logic        count_clr;
        logic        irq;
    } tdmtx_reg_t;

    tdmtx_link_t lq;
    tdmtx_link_t ld;
    tdmtx_reg_t  rq;
    tdmtx_reg_t  rd;

    tdmtx_sync_if #(.W(PIN_W)) pin_if ();
    tdmtx_sync_if #(.W(5))     to_link_if ();
    tdmtx_sync_if #(.W(18))    to_reg_if ();

    logic [15:0] status_l;

    assign pin_if.async_in = {phase_zero_pulse, phase_one_pulse,
                              bus_tx_addr, switch_addr, return_response,
                              bus_reject, bus_truncate, bus_master};

    tdmtx_sync #(.W(PIN_W)) u_pin_sync (
        .clk  (link_clk),
        .port (pin_if)
    );

    // Register side levels and toggles into the link domain
    assign to_link_if.async_in = {srst, rq.cmd[tdmtx_pkg::CMD_START],
                                  rq.init_tgl, rq.rd_tgl, count_armed};

    tdmtx_sync #(.W(5)) u_to_link (
        .clk  (link_clk),
        .port (to_link_if)
    );

    // Status levels and event toggles back to the register side
    assign to_reg_if.async_in = {lq.trunc_tgl, lq.irq_tgl, status_l};

    tdmtx_sync #(.W(18)) u_to_reg (
        .clk  (clk),
        .port (to_reg_if)
    );

    // Synced link pins, unpacked
    logic                       s_tp0;
    logic                       s_tp1;
    logic [tdmtx_pkg::ADDR_W-1:0] s_addr;
    logic [tdmtx_pkg::ADDR_W-1:0] s_sw;
    logic [1:0]                 s_ret;
    logic                       s_reject;
    logic                       s_trunc;
    logic                       s_master;
    logic                       lrst;
    logic                       s_start;
    logic                       s_init;
    logic                       s_rd;
    logic                       s_armed;

    assign {s_tp0, s_tp1, s_addr, s_sw, s_ret,
            s_reject, s_trunc, s_master} = pin_if.sync_out;
    assign {lrst, s_start, s_init, s_rd, s_armed} = to_link_if.sync_out;

    // Forward code for the message state
    function automatic logic [1:0] fwd_code(
        input tdmtx_pkg::tdmtx_state_t st
    );
        case (st)
            tdmtx_pkg::TS_DATA: fwd_code = tdmtx_pkg::RSP_DATA;
            tdmtx_pkg::TS_LAST: fwd_code = tdmtx_pkg::RSP_CHECK;
            tdmtx_pkg::TS_WAIT: fwd_code = tdmtx_pkg::RSP_WAIT;
            default:            fwd_code = tdmtx_pkg::RSP_ZERO;
        endcase
    endfunction

    // Status word seen by software
    always_comb begin
        status_l                         = tdmtx_pkg::RST_STATUS;
        status_l[tdmtx_pkg::ST_FWD0]     = lq.fwd[0];
        status_l[tdmtx_pkg::ST_FWD1]     = lq.fwd[1];
        status_l[tdmtx_pkg::ST_RET0]     = lq.ret[0];
        status_l[tdmtx_pkg::ST_RET1]     = lq.ret[1];
        status_l[tdmtx_pkg::ST_OCCUPIED] = lq.occupied;
        status_l[tdmtx_pkg::ST_REJECT]   = lq.rejected;
        status_l[tdmtx_pkg::ST_LIVE]     = lq.live;
        status_l[tdmtx_pkg::ST_SUCCESS]  = lq.success;
        status_l[tdmtx_pkg::ST_FAULT]    = lq.fault;
        status_l[tdmtx_pkg::ST_ERR]      = lq.err;
    end

    // Link controller: slice claim, response, capture, message end
    always_comb begin
        logic tp0_rise;
        logic tp1_fall;
        logic first_pend;
        tp0_rise    = s_tp0 & ~lq.tp0_d;
        tp1_fall    = ~s_tp1 & lq.tp1_d;
        first_pend  = s_start & (lq.st == tdmtx_pkg::TS_IDLE) & ~lq.err;
        ld          = lq;
        ld.tp0_d    = s_tp0;
        ld.tp1_d    = s_tp1;
        ld.pop      = 1'b0;
        ld.flush    = 1'b0;
        ld.crc_clr  = 1'b0;
        ld.cap      = 1'b0;
        ld.teardown = 1'b0;
        ld.init_seen = s_init;
        ld.rd_seen  = s_rd;
        if (tp0_rise) begin
            ld.term = 1'b0;
            if ((s_addr == s_sw) && (lq.live || first_pend)) begin
                ld.claimed = 1'b1;
                if (first_pend) begin
                    ld.st       = tdmtx_pkg::TS_DATA;
                    ld.success  = 1'b0;
                    ld.rejected = 1'b0;
                end
                if (lq.freeze) begin
                    ld.fwd       = tdmtx_pkg::RSP_ZERO;
                    ld.zero_sent = 1'b1;
                end else if (!lq.err) begin
                    ld.fwd = fwd_code(ld.st);
                end
            end
        end
        if (tp1_fall && lq.claimed) begin
            ld.claimed = 1'b0;
            ld.term = s_master;
            if (lq.zero_sent) begin
                ld.teardown  = 1'b1;
                ld.zero_sent = 1'b0;
                ld.freeze    = 1'b0;
                ld.live      = 1'b0;
                ld.st        = tdmtx_pkg::TS_IDLE;
            end else if (!lq.err) begin
                ld.cap = 1'b1;
                ld.ret = s_ret;
                if (s_reject) begin
                    ld.rejected = 1'b1;
                    ld.teardown = 1'b1;
                    ld.irq_tgl  = ~lq.irq_tgl;
                    ld.live     = 1'b0;
                    ld.st       = tdmtx_pkg::TS_IDLE;
                end else if (s_ret == tdmtx_pkg::RET_NONE && !lq.live
                             && lq.st == tdmtx_pkg::TS_DATA) begin
                    ld.occupied = 1'b1;
                    ld.err      = 1'b1;
                    ld.teardown = 1'b1;
                    ld.st       = tdmtx_pkg::TS_IDLE;
                end else if (s_ret == tdmtx_pkg::RET_FAIL) begin
                    ld.fault = 1'b1;
                    ld.err   = 1'b1;
                    if (lq.st == tdmtx_pkg::TS_LAST) begin
                        ld.teardown = 1'b1;
                        ld.live     = 1'b0;
                        ld.st       = tdmtx_pkg::TS_IDLE;
                    end else begin
                        ld.freeze = 1'b1;
                    end
                end else begin
                    if (s_trunc) begin
                        ld.trunc_tgl = ~lq.trunc_tgl;
                        ld.flush     = 1'b1;
                        ld.truncated = 1'b1;
                    end
                    case (lq.st)
                        tdmtx_pkg::TS_DATA: begin
                            if (s_ret == tdmtx_pkg::RET_ACCEPT
                                && !fifo_empty) begin
                                ld.pop  = 1'b1;
                                ld.live = 1'b1;
                            end
                        end
                        tdmtx_pkg::TS_LAST: begin
                            if (s_ret == tdmtx_pkg::RET_ACCEPT
                                || s_ret == tdmtx_pkg::RET_CHKOK) begin
                                ld.crc_clr    = 1'b1;
                                ld.final_word = 1'b0;
                                ld.st         = tdmtx_pkg::TS_WAIT;
                            end
                        end
                        tdmtx_pkg::TS_WAIT: begin
                            if (s_ret == tdmtx_pkg::RET_NONE) begin
                                ld.success   = ~lq.truncated;
                                ld.rejected  = lq.rejected | lq.truncated;
                                ld.truncated = 1'b0;
                                ld.live      = 1'b0;
                                ld.teardown  = 1'b1;
                                ld.st        = tdmtx_pkg::TS_IDLE;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        if (lq.st == tdmtx_pkg::TS_DATA && lq.live && fifo_empty
            && !s_armed && !lq.pop && !lq.claimed && !lq.err) begin
            ld.final_word = 1'b1;
            ld.st         = tdmtx_pkg::TS_LAST;
        end
        if (s_rd != lq.rd_seen) begin
            ld.pop  = 1'b1;
            ld.live = 1'b1;
        end
        if (s_init != lq.init_seen) begin
            ld.live       = 1'b0;
            ld.final_word = 1'b0;
            ld.freeze     = 1'b0;
            ld.zero_sent  = 1'b0;
            ld.err        = 1'b0;
            ld.fault      = 1'b0;
            ld.occupied   = 1'b0;
            ld.truncated  = 1'b0;
            ld.claimed    = 1'b0;
            ld.st         = tdmtx_pkg::TS_IDLE;
        end
        if (lq.final_word) begin
            ld.data = crc_ready ? crc_word : 16'h0000;
        end else begin
            ld.data = fifo_word;
        end
        ld.fwd_pin = ld.claimed ? ld.fwd : tdmtx_pkg::RSP_ZERO;
        ld.ctl_oe  = ld.claimed | ld.term;
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            lq    <= '0;
            lq.st <= tdmtx_pkg::TS_IDLE;
        end else begin
            lq <= ld;
        end
    end

    // Register side: command writes, event pulses
    always_comb begin
        rd           = rq;
        rd.trunc_prev = to_reg_if.sync_out[17];
        rd.irq_prev  = to_reg_if.sync_out[16];
        rd.count_clr = to_reg_if.sync_out[17] ^ rq.trunc_prev;
        rd.irq       = to_reg_if.sync_out[16] ^ rq.irq_prev;
        if (cmd_wr) begin
            // Only start is held; init and read are one-shot toggles
            rd.cmd = tdmtx_pkg::RST_CMD;
            rd.cmd[tdmtx_pkg::CMD_START] = cmd_wdata[tdmtx_pkg::CMD_START];
            if (cmd_wdata[tdmtx_pkg::CMD_INIT]) begin
                rd.init_tgl = ~rq.init_tgl;
            end
            if (cmd_wdata[tdmtx_pkg::CMD_RD_SILO]) begin
                rd.rd_tgl = ~rq.rd_tgl;
            end
        end
    end

    // Toggles reset low so both domains agree after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            rq     <= '0;
            rq.cmd <= tdmtx_pkg::RST_CMD;
        end else begin
            rq <= rd;
        end
    end

    // Outputs, all from flops
    assign tx_command_reg        = rq.cmd;
    assign tx_status_reg         = to_reg_if.sync_out[15:0];
    assign count_pending_clr     = rq.count_clr;
    assign irq_req               = rq.irq;
    assign forward_response_o    = lq.fwd_pin;
    assign forward_response_oe   = lq.ctl_oe;
    assign data_o                = lq.data;
    assign data_oe               = lq.claimed;
    assign fifo_pop_strobe       = lq.pop;
    assign fifo_flush            = lq.flush;
    assign crc_clear             = lq.crc_clr;
    assign return_capture_strobe = lq.cap;
    assign channel_teardown      = lq.teardown;
endmodule

// ### core/tdmtx_pkg.sv
// Purpose: Shared constants for the TDM time-slice transmit controller.
// Assumes: Response codes and bit positions are used by the controller
//          and by whoever drives the remote receiver in a bench.
// Notes:   All flags reset to zero.
package tdmtx_pkg;

    // Link address width and data word width
    localparam int ADDR_W = 5;
    localparam int WORD_W = 16;

    // Forward response codes, sender to receiver
    localparam logic [1:0] RSP_ZERO  = 2'h0;
    localparam logic [1:0] RSP_DATA  = 2'h1;
    localparam logic [1:0] RSP_CHECK = 2'h2;
    localparam logic [1:0] RSP_WAIT  = 2'h3;

    // Return response codes, receiver to sender
    localparam logic [1:0] RET_NONE   = 2'h0;
    localparam logic [1:0] RET_ACCEPT = 2'h1;
    localparam logic [1:0] RET_FAIL   = 2'h2;
    localparam logic [1:0] RET_CHKOK  = 2'h3;

    // Command register bit positions
    localparam int CMD_START   = 0;
    localparam int CMD_INIT    = 1;
    localparam int CMD_RD_SILO = 7;

    // Status register bit positions
    localparam int ST_FWD0     = 0;
    localparam int ST_FWD1     = 1;
    localparam int ST_RET0     = 2;
    localparam int ST_RET1     = 3;
    localparam int ST_OCCUPIED = 4;
    localparam int ST_REJECT   = 5;
    localparam int ST_LIVE     = 6;
    localparam int ST_SUCCESS  = 7;
    localparam int ST_FAULT    = 12;
    localparam int ST_ERR      = 15;

    // Reset values
    localparam logic [15:0] RST_CMD    = 16'h0000;
    localparam logic [15:0] RST_STATUS = 16'h0000;

    // Transmitter message state, one-hot
    typedef enum logic [3:0] {
        TS_IDLE = 4'h1,
        TS_DATA = 4'h2,
        TS_LAST = 4'h4,
        TS_WAIT = 4'h8
    } tdmtx_state_t;

endpackage

// ### core/tdmtx_sync_if.sv
// Purpose: Carries a group of levels into a two-stage synchroniser.
// Assumes: Each bit is a level or a toggle, never a one-cycle pulse.
// Notes:   Bits are resolved independently; no word coherence.
`timescale 1ns/1ps
interface tdmtx_sync_if #(parameter int W = 1);
    logic [W-1:0] async_in;
    logic [W-1:0] sync_out;
    modport sink (input async_in, output sync_out);
    modport user (output async_in, input sync_out);
endinterface

// ### core/tdmtx_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of levels.
// Assumes: Destination clock on clk.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module tdmtx_sync #(
    parameter int W = 1
) (
    input wire logic     clk,  // Destination clock
    tdmtx_sync_if.sink   port  // Level in, synced level out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tdmtx_sync_t;

    tdmtx_sync_t q;
    tdmtx_sync_t d;

    // Stage chain
    always_comb begin
        d    = q;
        d.s1 = port.async_in;
        d.s2 = q.s1;
    end

    // No reset: contents are flushed within two edges
    always_ff @(posedge clk) begin
        q <= d;
    end

    assign port.sync_out = q.s2;
endmodule

// ### bench/tdmtx_ctrl_monitor.sv
// Purpose: Port checks for the slice transmit controller.
// Assumes: Link logic is held in reset while srst is high.
// Notes:   Pulses are one cycle wide in their own domain.
`timescale 1ns/1ps
module tdmtx_ctrl_monitor (
    input wire logic        clk,                   // Register clock
    input wire logic        srst,                  // Sync reset
    input wire logic        link_clk,              // Link clock
    input wire logic        cmd_wr,                // Command write
    input wire logic [15:0] cmd_wdata,             // Command data
    input wire logic [15:0] tx_command_reg,        // Command readback
    input wire logic        irq_req,               // Interrupt pulse
    input wire logic [1:0]  forward_response_o,    // Response pins
    input wire logic        forward_response_oe,   // Response enable
    input wire logic        data_oe,               // Data enable
    input wire logic        fifo_pop_strobe,       // Pop pulse
    input wire logic        return_capture_strobe, // Capture pulse
    input wire logic        channel_teardown       // Teardown pulse
);
    // Register side: only the start bit is kept
    cmd_store_a: assert property (@(posedge clk)
        disable iff (srst)
        cmd_wr |=> tx_command_reg == {15'h0000, $past(cmd_wdata[0])})
        else $error("command readback wrong");
    irq_pulse_a: assert property (@(posedge clk)
        disable iff (srst) irq_req |=> !irq_req)
        else $error("interrupt pulse too long");
    // Link side: enables, idle level and one-cycle strobes
    oe_pair_a: assert property (@(posedge link_clk)
        disable iff (srst) data_oe |-> forward_response_oe)
        else $error("data driven without response");
    idle_zero_a: assert property (@(posedge link_clk)
        disable iff (srst) forward_response_oe && !data_oe
        |-> forward_response_o == 2'h0)
        else $error("idle response not zero");
    pop_pulse_a: assert property (@(posedge link_clk)
        disable iff (srst) fifo_pop_strobe |=> !fifo_pop_strobe)
        else $error("pop pulse too long");
    capture_pulse_a: assert property (@(posedge link_clk)
        disable iff (srst)
        return_capture_strobe |=> !return_capture_strobe)
        else $error("capture pulse too long");
    capture_ends_claim_a: assert property (@(posedge link_clk)
        disable iff (srst) return_capture_strobe |-> !data_oe)
        else $error("claim held past capture");
    tear_pulse_a: assert property (@(posedge link_clk)
        disable iff (srst) channel_teardown |=> !channel_teardown)
        else $error("teardown pulse too long");
endmodule
bind tdmtx_ctrl tdmtx_ctrl_monitor mon_u (.clk, .srst, .link_clk,
    .cmd_wr, .cmd_wdata, .tx_command_reg, .irq_req, .forward_response_o,
    .forward_response_oe, .data_oe, .fifo_pop_strobe,
    .return_capture_strobe, .channel_teardown);

// ### bench/tdmtx_remote_rx.sv
// Purpose: Remote receiver and slice timing on the link.
// Assumes: One slice at a time, called from the bench.
// Notes:   Released lines sit low, as the terminator forces; bus_tx_addr parks at ~OWN_ADDR.
`timescale 1ns/1ps
module tdmtx_remote_rx #(
    parameter logic [4:0] OWN_ADDR = 5'h05 // Our sender's address
) (
    input wire logic   link_clk,         // Link clock
    output logic       phase_zero_pulse, // Phase zero
    output logic       phase_one_pulse,  // Phase one
    output logic [4:0] bus_tx_addr,      // Slice owner
    output logic [1:0] return_response,  // Return code
    output logic       bus_reject,       // Reject line
    output logic       bus_truncate      // Truncate line
);
    // Drop every line low; park the slice owner address at ~OWN_ADDR
    task automatic rel;
        phase_zero_pulse <= 1'b0;
        phase_one_pulse <= 1'b0;
        bus_tx_addr <= ~OWN_ADDR;
        return_response <= 2'h0;
        bus_reject <= 1'b0;
        bus_truncate <= 1'b0;
    endtask
    initial rel();
    // One slice: phase zero, then phase one with the answer
    task automatic slice(input logic [1:0] code, input logic rej, trn);
        @(posedge link_clk);
        bus_tx_addr <= OWN_ADDR;
        phase_zero_pulse <= 1'b1;
        repeat (6) @(posedge link_clk);
        phase_zero_pulse <= 1'b0;
        phase_one_pulse <= 1'b1;
        return_response <= code;
        bus_reject <= rej;
        bus_truncate <= trn;
        repeat (6) @(posedge link_clk);
        phase_one_pulse <= 1'b0;
        // Answer held past the synchronised capture
        repeat (5) @(posedge link_clk);
        rel();
        repeat (4) @(posedge link_clk);
    endtask
endmodule

// ### bench/tdmtx_ctrl_bench.sv
// Purpose: Directed run of the slice transmit controller.
// Assumes: Remote receiver model drives the link side.
// Notes:   Status is read after its two-clock sync lag.
`timescale 1ns/1ps
module tdmtx_ctrl_bench;
    logic        clk, srst, link_clk, cmd_wr, count_armed, bus_master;
    logic        fifo_empty, crc_ready, phase_zero_pulse, phase_one_pulse;
    logic        bus_reject, bus_truncate, count_pending_clr, irq_req;
    logic        forward_response_oe, data_oe, fifo_pop_strobe, fifo_flush;
    logic        crc_clear, return_capture_strobe, channel_teardown;
    logic [15:0] cmd_wdata, tx_command_reg, tx_status_reg, data_o;
    logic [15:0] fifo_word, crc_word, last_data;
    logic [4:0]  bus_tx_addr, switch_addr;
    logic [1:0]  return_response, forward_response_o, last_fwd;
    int          num_errors, comparisons, pops, tears, flushes, clears;
    int          irqs, pclrs, caps;
    tdmtx_ctrl dut_u (.*);
    tdmtx_remote_rx #(.OWN_ADDR(5'h05)) rx_u (.*);
    // Two unrelated clocks
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #6 link_clk = ~link_clk;
    end
    // Tally link pulses, keep what was driven in the slice
    always @(posedge link_clk) begin
        if (fifo_pop_strobe === 1'b1) pops++;
        if (channel_teardown === 1'b1) tears++;
        if (fifo_flush === 1'b1) flushes++;
        if (crc_clear === 1'b1) clears++;
        if (return_capture_strobe === 1'b1) caps++;
        if (data_oe === 1'b1) begin
            last_fwd = forward_response_o;
            last_data = data_o;
        end
    end
    always @(posedge clk) begin
        if (irq_req === 1'b1) irqs++;
        if (count_pending_clr === 1'b1) pclrs++;
    end
    task automatic chk(input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic st(input int i, input logic v);
        chk({15'h0000, tx_status_reg[i]}, {15'h0000, v});
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_wr <= 1'b0;
    endtask
    task automatic sl(input logic [1:0] code, input logic rej, trn);
        rx_u.slice(code, rej, trn);
        repeat (8) @(posedge clk);
    endtask
    // Initialise, clear tallies, start a new message
    task automatic fresh;
        wr(16'h0002);
        repeat (10) @(posedge clk);
        {pops, tears, flushes, clears, irqs, pclrs, caps} = '0;
        fifo_empty <= 1'b0;
        count_armed <= 1'b1;
        wr(16'h0001);
        repeat (4) @(posedge clk);
    endtask
    task automatic summarize;
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard: whole run should take a few microseconds
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        {srst, cmd_wr, count_armed, fifo_empty} = 4'h8;
        {bus_master, crc_ready} = 2'h3;
        cmd_wdata = 16'h0000;
        fifo_word = 16'h1234;
        crc_word = 16'hA5C3;
        switch_addr = 5'h05;
        {num_errors, comparisons, pops, tears, flushes, clears} = '0;
        {irqs, pclrs, caps, last_fwd, last_data} = '0;
        // Link side still sees reset through its synchroniser
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(tx_command_reg, tdmtx_pkg::RST_CMD);
        chk(tx_status_reg, tdmtx_pkg::RST_STATUS);
        // Whole message: word, check character, wait, finish
        fresh();
        chk(tx_command_reg, 16'h0001);
        sl(tdmtx_pkg::RET_ACCEPT, 1'b0, 1'b0);
        chk({14'h0000, last_fwd}, {14'h0000, tdmtx_pkg::RSP_DATA});
        chk(last_data, fifo_word);
        chk(16'(pops), 16'h0001);
        st(tdmtx_pkg::ST_RET0, 1'b1);
        st(tdmtx_pkg::ST_RET1, 1'b0);
        st(tdmtx_pkg::ST_LIVE, 1'b1);
        chk(16'(caps), 16'h0001);
        chk({14'h0000, forward_response_oe, data_oe}, 16'h0002);
        chk({14'h0000, forward_response_o}, 16'h0000);
        // Check character not ready yet: data lines held at zero
        fifo_empty <= 1'b1;
        count_armed <= 1'b0;
        crc_ready <= 1'b0;
        repeat (12) @(posedge clk);
        chk(data_o, 16'h0000);
        crc_ready <= 1'b1;
        sl(tdmtx_pkg::RET_CHKOK, 1'b0, 1'b0);
        chk({14'h0000, last_fwd}, {14'h0000, tdmtx_pkg::RSP_CHECK});
        chk(last_data, crc_word);
        chk(16'(clears), 16'h0001);
        sl(tdmtx_pkg::RET_NONE, 1'b0, 1'b0);
        st(tdmtx_pkg::ST_SUCCESS, 1'b1);
        chk(16'(tears), 16'h0001);
        // Maintenance pop, then a rejected word
        fresh();
        wr(16'h0081);
        repeat (10) @(posedge clk);
        chk(16'(pops), 16'h0001);
        sl(tdmtx_pkg::RET_ACCEPT, 1'b1, 1'b0);
        st(tdmtx_pkg::ST_REJECT, 1'b1);
        chk(16'(irqs), 16'h0001);
        chk(16'(tears), 16'h0001);
        wr(16'h0002);
        repeat (10) @(posedge clk);
        chk(tx_command_reg, 16'h0000);
        st(tdmtx_pkg::ST_LIVE, 1'b0);
        // Receiver offline on the first word, unit not link master
        fresh();
        bus_master <= 1'b0;
        sl(tdmtx_pkg::RET_NONE, 1'b0, 1'b0);
        st(tdmtx_pkg::ST_OCCUPIED, 1'b1);
        chk(16'(tears), 16'h0001);
        chk({15'h0000, forward_response_oe}, 16'h0000);
        bus_master <= 1'b1;
        // Failed word: frozen, zero response, late teardown
        fresh();
        sl(tdmtx_pkg::RET_ACCEPT, 1'b0, 1'b0);
        sl(tdmtx_pkg::RET_FAIL, 1'b0, 1'b0);
        st(tdmtx_pkg::ST_FAULT, 1'b1);
        chk(16'(tears), 16'h0000);
        sl(tdmtx_pkg::RET_ACCEPT, 1'b0, 1'b0);
        chk({14'h0000, last_fwd}, 16'h0000);
        chk(16'(pops), 16'h0001);
        chk(16'(caps), 16'h0002);
        chk(16'(tears), 16'h0001);
        // Check character refused: teardown in the same slice
        fresh();
        sl(tdmtx_pkg::RET_ACCEPT, 1'b0, 1'b0);
        fifo_empty <= 1'b1;
        count_armed <= 1'b0;
        repeat (12) @(posedge clk);
        sl(tdmtx_pkg::RET_FAIL, 1'b0, 1'b0);
        chk(16'(tears), 16'h0001);
        // Truncated message
        fresh();
        sl(tdmtx_pkg::RET_ACCEPT, 1'b0, 1'b1);
        chk(16'(pclrs), 16'h0001);
        chk(16'(flushes), 16'h0001);
        // Count dropped by the truncate; message ends as rejected
        fifo_empty <= 1'b1;
        count_armed <= 1'b0;
        repeat (12) @(posedge clk);
        sl(tdmtx_pkg::RET_CHKOK, 1'b0, 1'b0);
        sl(tdmtx_pkg::RET_NONE, 1'b0, 1'b0);
        st(tdmtx_pkg::ST_REJECT, 1'b1);
        st(tdmtx_pkg::ST_SUCCESS, 1'b0);
        summarize();
    end
endmodule
